// ---- logic/rsp_mac_end.sv ----
// MAC end: drives the link clock and frames, APB registers for software
`timescale 1ns/10ps
`include "rsp_params.svh"
module rsp_mac_end (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Link toward the device
  rsp_link_if.mac link,
  // APB slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // Interrupt
  output logic irq_out
);

  // ==========================================
  // State
  // Pin bits: 0 carrier/valid, 2:1 data, 3 error, 4 serial rx
  typedef struct packed {
    logic [4:0] p1;
    logic [4:0] p2;
    logic [4:0] p3;
    logic [2:0] div;
    logic ref_clk;
    logic [5:0] ctrl;
    logic [4:0] stat;
    logic [4:0] ien;
    logic [9:0] txh;
    logic tx_full;
    logic [8:0] rxb;
    logic [7:0] lstat;
    logic tx_en;
    logic [1:0] txd;
    logic sync;
    logic stx;
    logic last;
    logic [3:0] tbit;
    logic [3:0] trep;
    logic [3:0] spos;
    logic [9:0] tsh;
    logic [3:0] rbit;
    logic [3:0] rrep;
    logic [9:0] rsh;
    logic rx_on;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic irq;
  } rsp_mac_st_t;

  rsp_mac_st_t s;
  rsp_mac_st_t n;
  logic rise;
  logic fall;
  logic fast;
  logic tick;
  logic acc;
  logic [4:0] ev;
  logic [4:0] clr;

  // ==========================================
  // Next state
  always_comb begin
    n = s;
    ev = 5'h00;
    clr = 5'h00;
    n.p1 = {link.srx, link.rx_er, link.rxd, link.crs_dv};
    n.p2 = s.p1;
    n.p3 = s.p2;
    fast = s.ctrl[`RSP_CTRL_SPEED];
    // Divider makes the link clock; inputs sampled as it rises
    // Low half first, so the first high phase after reset is full length
    rise = (s.div == `RSP_DIV_HALF - 3'h1);
    fall = (s.div == `RSP_DIV_LAST);
    n.div = fall ? 3'h0 : s.div + 3'h1;
    n.ref_clk = (n.div >= `RSP_DIV_HALF);
    tick = 1'b0;
    // Outputs change mid-period so the device samples stable levels
    if (fall && !s.ctrl[`RSP_CTRL_SERIAL]) begin
      if (s.tx_en) begin
        tick = fast || s.trep == `RSP_REP_LAST;
        n.trep = tick ? 4'h0 : s.trep + 4'h1;
        if (tick && s.tbit == `RSP_DIBIT_LAST) begin
          if (!s.last && s.tx_full) begin
            n.tsh = s.txh;
            n.txd = s.txh[1:0];
            n.last = s.txh[`RSP_TXD_LAST];
            n.tx_full = 1'b0;
            n.tbit = 4'h0;
          end else begin
            // An underrun ends the frame early
            n.tx_en = 1'b0;
            n.txd = 2'h0;
            ev[`RSP_EV_TXD] = 1'b1;
          end
        end else if (tick) begin
          n.tbit = s.tbit + 4'h1;
          n.txd = s.tsh[3'(n.tbit) * 2 +: 2];
        end
      end else if (s.tx_full) begin
        n.tx_en = 1'b1;
        n.txd = s.txh[1:0];
        n.tsh = s.txh;
        n.last = s.txh[`RSP_TXD_LAST];
        n.tx_full = 1'b0;
        n.tbit = 4'h0;
        n.trep = 4'h0;
      end
    end
    if (fall && s.ctrl[`RSP_CTRL_SERIAL]) begin
      n.spos = (s.spos == `RSP_SEG_LAST) ? 4'h0 : s.spos + 4'h1;
      n.sync = (s.spos == 4'h0);
      if (s.spos == 4'h0) begin
        n.trep = (fast || s.trep == `RSP_REP_LAST) ? 4'h0 :
          s.trep + 4'h1;
        if (s.trep == 4'h0 || fast) begin
          if (s.tx_full) begin
            n.tsh = {s.txh[7:0], 1'b1, s.txh[`RSP_TXD_ERR]};
            n.tx_full = 1'b0;
            ev[`RSP_EV_TXD] = s.txh[`RSP_TXD_LAST];
          end else begin
            n.tsh = {3'h7, s.ctrl[`RSP_CTRL_JABBER:`RSP_CTRL_SPEED],
              s.ctrl[`RSP_CTRL_FORCE], 2'h0};
          end
        end
        n.stx = n.tsh[0];
      end else begin
        n.stx = s.tsh[s.spos];
      end
    end
    if (rise && !s.ctrl[`RSP_CTRL_SERIAL]) begin
      ev[`RSP_EV_COL] = s.tx_en & s.p3[0];
      if (s.p3[0]) begin
        n.rrep = (fast || s.rrep == `RSP_REP_LAST) ? 4'h0 :
          s.rrep + 4'h1;
        // Leading zero di-bits are the wait for decoding
        if ((fast || s.rrep == 4'h0) && (s.rx_on || s.p3[2:1] != 2'h0)) begin
          n.rx_on = 1'b1;
          n.rsh = {s.p3[2:1], s.rsh[9:2]};
          n.rbit = s.rbit + 4'h1;
          if (s.rbit == `RSP_DIBIT_LAST) begin
            n.rbit = 4'h0;
            n.rxb = {s.p3[3], n.rsh[9:2]};
            ev[`RSP_EV_RXB] = 1'b1;
          end
        end
        ev[`RSP_EV_ERR] = s.p3[3];
      end else begin
        ev[`RSP_EV_END] = s.rx_on;
        n.rx_on = 1'b0;
        n.rbit = 4'h0;
        n.rrep = 4'h0;
      end
    end
    if (rise && s.ctrl[`RSP_CTRL_SERIAL]) begin
      // The device answers one clock behind the sync
      n.rsh = {s.p3[4], s.rsh[9:1]};
      if (s.spos == 4'h1) begin
        n.rrep = (fast || s.rrep == `RSP_REP_LAST) ? 4'h0 :
          s.rrep + 4'h1;
        if (fast || s.rrep == 4'h0) begin
          if (n.rsh[1]) begin
            n.rxb = {1'b0, n.rsh[9:2]};
            n.rx_on = 1'b1;
            ev[`RSP_EV_RXB] = 1'b1;
          end else begin
            n.lstat = n.rsh[9:2];
            ev[`RSP_EV_END] = s.rx_on;
            ev[`RSP_EV_ERR] = s.rx_on & n.rsh[2];
            n.rx_on = 1'b0;
          end
        end
      end
    end
    // APB: one wait state, then the access completes
    acc = psel_in & penable_in & s.pready;
    n.pready = psel_in & penable_in & ~s.pready;
    if (n.pready) begin
      n.pslverr = 1'b0;
      case (paddr_in)
        `RSP_OFF_CTRL: n.prdata = {26'h0, s.ctrl};
        `RSP_OFF_STAT: n.prdata = {27'h0, s.stat};
        `RSP_OFF_IEN: n.prdata = {27'h0, s.ien};
        `RSP_OFF_ICLR: n.prdata = 32'h0;
        `RSP_OFF_TXD: n.prdata = {s.tx_full, 31'h0};
        `RSP_OFF_RXD: n.prdata = {23'h0, s.rxb};
        `RSP_OFF_LSTAT: n.prdata = {24'h0, s.lstat};
        default: begin
          n.prdata = 32'h0;
          n.pslverr = 1'b1;
        end
      endcase
    end
    if (acc && pwrite_in) begin
      case (paddr_in)
        `RSP_OFF_CTRL: n.ctrl = pwdata_in[5:0];
        `RSP_OFF_IEN: n.ien = pwdata_in[4:0];
        `RSP_OFF_ICLR: clr = pwdata_in[4:0];
        `RSP_OFF_TXD: begin
          if (!s.tx_full) begin
            n.txh = pwdata_in[9:0];
            n.tx_full = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end
    // A new event beats a clear in the same cycle
    n.stat = (s.stat & ~clr) | ev;
    n.irq = |(n.stat & n.ien);
  end

  // ==========================================
  // Registers
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign link.ref_clk = s.ref_clk;
  assign link.tx_en = s.tx_en;
  assign link.txd = s.txd;
  assign link.sync = s.sync;
  assign link.stx = s.stx;
  assign prdata_out = s.prdata;
  assign pready_out = s.pready;
  assign pslverr_out = s.pslverr;
  assign irq_out = s.irq;

endmodule

// ---- logic/rsp_params.svh ----
// Constants of the reduced and serial PHY-MAC data port
`ifndef RSP_PARAMS_SVH
`define RSP_PARAMS_SVH
// What this block does
// - MAC supplies continuous reference clock for reduced mode
// - MAC frames transmit enable on reference clock
// - Transmit di-bits taken only while enable high
// - Carrier/data-valid rises at once on carrier
// - Carrier/data-valid spans first to final di-bit
// - Receive data stays 00 until decoding starts
// - Two receive bits per clock when fast, per ten clocks when slow, 00 when idle
// - Receive error flags symbol errors, ignored when idle
// - MAC builds collision from enable and carrier
// - Straps 010 select serial mode at reset
// - Straps 001 select reduced mode at reset
// - MAC supplies continuous clock for serial mode
// - MAC sends sync pulse every ten clocks
// - Slow transmit segments repeat ten times
// - Transmit segment: error, enable, byte or status
// - Slow receive segments repeat ten times
// - Receive segment: carrier, valid, byte or status

// ==========================================
// Timing
`define RSP_CLK_NS 50
`define RSP_LINK_NS 400
`define RSP_DIV_LAST 3'((`RSP_LINK_NS / `RSP_CLK_NS) - 1)
`define RSP_DIV_HALF 3'((`RSP_LINK_NS / `RSP_CLK_NS) / 2)
`define RSP_SEG_LAST 4'h9
`define RSP_REP_LAST 4'h9
`define RSP_DIBIT_LAST 4'h3
`define RSP_BOOT_DONE 2'h3

// ==========================================
// Straps
`define RSP_STRAP_REDUCED 3'h1
`define RSP_STRAP_SERIAL 3'h2

// ==========================================
// Register map and fields
`define RSP_OFF_CTRL 8'h00
`define RSP_OFF_STAT 8'h04
`define RSP_OFF_IEN 8'h08
`define RSP_OFF_ICLR 8'h0c
`define RSP_OFF_TXD 8'h10
`define RSP_OFF_RXD 8'h14
`define RSP_OFF_LSTAT 8'h18
`define RSP_CTRL_SERIAL 0
`define RSP_CTRL_SPEED 1
`define RSP_CTRL_DUPLEX 2
`define RSP_CTRL_LINK 3
`define RSP_CTRL_JABBER 4
`define RSP_CTRL_FORCE 5
`define RSP_TXD_LAST 8
`define RSP_TXD_ERR 9
`define RSP_TXD_FULL 31
`define RSP_EV_RXB 0
`define RSP_EV_END 1
`define RSP_EV_ERR 2
`define RSP_EV_COL 3
`define RSP_EV_TXD 4
`define RSP_CTRL_RESET 6'h00
`endif

// ---- logic/rsp_pkg.sv ----
// Types used by the device end of the port
package rsp_pkg;
  typedef enum logic [1:0] {mode_off, mode_reduced, mode_serial} rsp_mode_t;
endpackage

// ---- logic/rsp_link_if.sv ----
// Link wires between the MAC end and the device end
`timescale 1ns/10ps
interface rsp_link_if;
  logic ref_clk;
  logic tx_en;
  logic [1:0] txd;
  logic crs_dv;
  logic [1:0] rxd;
  logic rx_er;
  logic sync;
  logic stx;
  logic srx;
  modport mac (
    output ref_clk, tx_en, txd, sync, stx,
    input crs_dv, rxd, rx_er, srx
  );
  modport phy (
    input ref_clk, tx_en, txd, sync, stx,
    output crs_dv, rxd, rx_er, srx
  );
endinterface

// ---- logic/rsp_phy_end.sv ----
// Device end: recovers transmit bytes, sends receive bytes and status
`timescale 1ns/10ps
`include "rsp_params.svh"
module rsp_phy_end (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Link toward the MAC
  rsp_link_if.phy link,
  // Straps and line status
  input wire logic [2:0] straps_in,
  input wire logic speed_in,
  input wire logic duplex_in,
  input wire logic link_in,
  input wire logic jabber_in,
  // Receive path from the line
  input wire logic carrier_in,
  input wire logic [7:0] rx_byte_in,
  input wire logic rx_err_in,
  input wire logic false_carrier_in,
  output logic rx_take_out,
  // Transmit path to the line
  output logic [7:0] tx_byte_out,
  output logic tx_valid_out,
  output logic tx_err_out,
  output logic [3:0] mac_stat_out,
  output logic [1:0] mode_out
);

  // ==========================================
  // State
  // Pin bits: 0 ref, 1 enable, 3:2 data, 4 sync, 5 serial tx, 8:6 straps
  typedef struct packed {
    logic [8:0] p1;
    logic [8:0] p2;
    logic [8:0] p3;
    logic ref_lvl;
    logic [1:0] boot;
    rsp_pkg::rsp_mode_t mode;
    logic [3:0] tbit;
    logic [3:0] trep;
    logic [9:0] tsh;
    logic [3:0] rbit;
    logic [3:0] rrep;
    logic [9:0] rsh;
    logic [9:0] rseg;
    logic rx_act;
    logic err_acc;
    logic prev_err;
    logic [7:0] tx_byte;
    logic tx_valid;
    logic tx_err;
    logic [3:0] mac_stat;
    logic rx_take;
    logic crs_dv;
    logic [1:0] rxd;
    logic rx_er;
    logic srx;
  } rsp_phy_st_t;

  rsp_phy_st_t s;
  rsp_phy_st_t n;
  logic rise;
  logic [9:0] seg;

  // ==========================================
  // Next state
  always_comb begin
    n = s;
    rise = 1'b0;
    seg = s.rseg;
    // Only the second stage reads the first
    n.p1 = {straps_in, link.stx, link.sync, link.txd, link.tx_en,
      link.ref_clk};
    n.p2 = s.p1;
    n.p3 = s.p2;
    n.tx_valid = 1'b0;
    n.rx_take = 1'b0;
    if (s.p2[0] == s.p3[0]) begin
      n.ref_lvl = s.p3[0];
      rise = s.p3[0] & ~s.ref_lvl;
    end
    // Straps are caught once, after the pin chain has settled
    // Straps count only once the second and third stages agree
    if (s.boot != `RSP_BOOT_DONE && s.p2[8:6] == s.p3[8:6]) begin
      n.boot = s.boot + 2'h1;
      if (s.boot == 2'h2) begin
        case (s.p3[8:6])
          `RSP_STRAP_SERIAL: n.mode = rsp_pkg::mode_serial;
          `RSP_STRAP_REDUCED: n.mode = rsp_pkg::mode_reduced;
          default: n.mode = rsp_pkg::mode_off;
        endcase
      end
    end
    case (s.mode)
      rsp_pkg::mode_reduced: begin
        // Carrier does not wait for a reference edge
        if (carrier_in && !s.crs_dv) begin
          n.crs_dv = 1'b1;
        end
        if (rise) begin
          if (!s.p3[1]) begin
            n.tbit = 4'h0;
            n.trep = 4'h0;
          end else begin
            n.trep = (speed_in || s.trep == `RSP_REP_LAST) ? 4'h0 :
              s.trep + 4'h1;
            if (s.trep == 4'h0) begin
              n.tsh = {s.p3[3:2], s.tsh[9:2]};
              n.tbit = s.tbit + 4'h1;
              if (s.tbit == `RSP_DIBIT_LAST) begin
                n.tbit = 4'h0;
                n.tx_byte = n.tsh[9:2];
                n.tx_valid = 1'b1;
                n.tx_err = 1'b0;
              end
            end
          end
          if (s.crs_dv) begin
            n.rrep = (speed_in || s.rrep == `RSP_REP_LAST) ? 4'h0 :
              s.rrep + 4'h1;
            if (s.rrep == 4'h0) begin
              if (!s.rx_act || s.rbit == `RSP_DIBIT_LAST) begin
                if (carrier_in) begin
                  n.rx_act = 1'b1;
                  n.rbit = 4'h0;
                  n.rxd = rx_byte_in[1:0];
                  n.rsh = {4'h0, rx_byte_in[7:2]};
                  n.rx_take = 1'b1;
                end else begin
                  n.crs_dv = 1'b0;
                  n.rx_act = 1'b0;
                  n.rxd = 2'h0;
                end
              end else begin
                n.rbit = s.rbit + 4'h1;
                n.rxd = s.rsh[1:0];
                n.rsh = {2'h0, s.rsh[9:2]};
              end
              n.rx_er = rx_err_in & n.rx_act & n.crs_dv;
            end
          end
        end
      end
      rsp_pkg::mode_serial: begin
        if (rise) begin
          // Transmit segment, error bit first
          n.tbit = s.p3[4] ? 4'h1 : s.tbit + 4'h1;
          n.tsh = {s.p3[5], s.tsh[9:1]};
          if (!s.p3[4] && s.tbit == `RSP_SEG_LAST) begin
            n.trep = (speed_in || s.trep == `RSP_REP_LAST) ? 4'h0 :
              s.trep + 4'h1;
            // Any one copy of ten will do
            if (s.trep == 4'h0) begin
              if (n.tsh[1]) begin
                n.tx_byte = n.tsh[9:2];
                n.tx_valid = 1'b1;
                n.tx_err = n.tsh[0];
              end else begin
                n.mac_stat = n.tsh[6:3];
              end
            end
          end
          // Receive segment, carrier bit first
          if (s.p3[4]) begin
            n.rrep = (speed_in || s.rrep == `RSP_REP_LAST) ? 4'h0 :
              s.rrep + 4'h1;
            if (s.rrep == 4'h0) begin
              if (carrier_in) begin
                seg = {rx_byte_in, 2'h3};
                n.rx_take = 1'b1;
                n.rx_act = 1'b1;
                n.err_acc = s.err_acc | rx_err_in;
              end else begin
                if (s.rx_act) begin
                  n.prev_err = s.err_acc;
                  n.err_acc = 1'b0;
                  n.rx_act = 1'b0;
                end
                seg = {1'b1, false_carrier_in, 1'b1, jabber_in, link_in,
                  duplex_in, speed_in, n.prev_err, 2'h0};
              end
            end
            n.rseg = seg;
            n.srx = seg[0];
            n.rsh = {1'b0, seg[9:1]};
          end else begin
            n.srx = s.rsh[0];
            n.rsh = {1'b0, s.rsh[9:1]};
          end
        end
      end
      default: begin
        n.crs_dv = 1'b0;
      end
    endcase
  end

  // ==========================================
  // Registers
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign link.crs_dv = s.crs_dv;
  assign link.rxd = s.rxd;
  assign link.rx_er = s.rx_er;
  assign link.srx = s.srx;
  assign rx_take_out = s.rx_take;
  assign tx_byte_out = s.tx_byte;
  assign tx_valid_out = s.tx_valid;
  assign tx_err_out = s.tx_err;
  assign mac_stat_out = s.mac_stat;
  assign mode_out = s.mode;

endmodule

// ---- tb/rsp_link_monitor.sv ----
// Checker of the link wires between the MAC end and the device end
`timescale 1ns/10ps
module rsp_link_monitor (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Link wires
  input wire logic ref_clk,
  input wire logic tx_en,
  input wire logic [1:0] txd,
  input wire logic crs_dv,
  input wire logic [1:0] rxd,
  input wire logic rx_er,
  input wire logic sync,
  input wire logic stx,
  input wire logic srx
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // ==========================================
  // Reduced mode
  a_txd_idle_zero: assert property (!tx_en |-> txd == 2'h0)
    else $error("txd not zero while enable low");
  a_rxd_idle_zero: assert property (!crs_dv |-> rxd == 2'h0)
    else $error("rxd not zero while carrier low");
  a_txen_on_fall: assert property ($changed(tx_en) |-> $fell(ref_clk))
    else $error("tx_en moved off the link clock fall");
  a_txd_on_fall: assert property ($changed(txd) |-> $fell(ref_clk))
    else $error("txd moved off the link clock fall");
  a_refclk_half: assert property (
    $rose(ref_clk) |-> ref_clk [*4] ##1 !ref_clk)
    else $error("link clock high phase wrong");
  a_rxd_low_half: assert property ($changed(rxd) |-> !ref_clk)
    else $error("rxd moved in the high half");
  a_rxer_low_half: assert property ($changed(rx_er) |-> !ref_clk)
    else $error("rx_er moved in the high half");
  a_rxd_zero_dv: assert property ($rose(crs_dv) |-> rxd == 2'h0)
    else $error("rxd not zero as carrier rose");
  // ==========================================
  // Serial mode, then covers of both modes
  a_sync_one_period: assert property (
    $rose(sync) |-> sync [*8] ##1 !sync)
    else $error("sync pulse width wrong");
  a_sync_every_ten: assert property ($rose(sync) |-> ##80 $rose(sync))
    else $error("sync spacing wrong");
  a_stx_on_fall: assert property ($changed(stx) |-> $fell(ref_clk))
    else $error("stx moved off the link clock fall");
  c_tx_frame: cover property ($rose(tx_en));
  c_rx_frame: cover property ($rose(crs_dv));
  c_rx_error: cover property (crs_dv && rx_er);
  c_serial: cover property ($rose(sync) ##1 srx);
endmodule

// ---- tb/tb.sv ----
// Testbench joining both ends of the port over the link
`timescale 1ns/10ps
`include "rsp_params.svh"
module tb;
  logic clk_in, rst_in, psel, penable, pwrite, pready, pslverr, irq, re;
  logic [7:0] paddr, rx_byte, tx_byte;
  logic [31:0] pwdata, prdata, rq;
  logic [2:0] straps;
  logic speed, duplex, link_up, jabber, carrier, rx_err, false_carrier;
  logic rx_take, tx_valid, tx_err;
  logic [3:0] mac_stat, b4;
  logic [1:0] mode;
  int n_mismatch, checks_done, cyc, seed;
  logic [7:0] rxq[$], txq[$], exq[$];
  rsp_link_if link ();
  rsp_phy_end rsp_phy_end_i (.clk_in(clk_in), .rst_in(rst_in),
    .link(link.phy), .straps_in(straps), .speed_in(speed),
    .duplex_in(duplex), .link_in(link_up), .jabber_in(jabber),
    .carrier_in(carrier), .rx_byte_in(rx_byte), .rx_err_in(rx_err),
    .false_carrier_in(false_carrier), .rx_take_out(rx_take),
    .tx_byte_out(tx_byte), .tx_valid_out(tx_valid), .tx_err_out(tx_err),
    .mac_stat_out(mac_stat), .mode_out(mode));
  rsp_mac_end rsp_mac_end_i (.clk_in(clk_in), .rst_in(rst_in),
    .link(link.mac), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .irq_out(irq));
  rsp_link_monitor rsp_link_monitor_i (.clk_in(clk_in), .rst_in(rst_in),
    .ref_clk(link.ref_clk), .tx_en(link.tx_en), .txd(link.txd),
    .crs_dv(link.crs_dv), .rxd(link.rxd), .rx_er(link.rx_er),
    .sync(link.sync), .stx(link.stx), .srx(link.srx));
  initial begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end
  task automatic check(input string nm, input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // ==========================================
  // APB master: request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk_in);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_in);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk_in);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k == 20) check("apb answer", 32'h0, 32'h1);
    rq = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_bit(input logic [7:0] a, input int b, input logic v);
    int k;
    k = 0;
    do begin
      apb(1'b0, a, 32'h0);
      k++;
    end while (rq[b] !== v && k < 3000);
    if (k == 3000) check("status wait", 32'h0, 32'h1);
  endtask
  task automatic do_reset(input logic [2:0] s);
    rst_in <= 1'b1;
    straps <= s;
    repeat (10) @(posedge clk_in);
    rst_in <= 1'b0;
    repeat (12) @(posedge clk_in);
  endtask
  // ==========================================
  // Frames
  task automatic tx_frame(input logic [5:0] ctrl, input int n);
    logic [7:0] b;
    speed <= ctrl[1];
    apb(1'b1, `RSP_OFF_CTRL, {26'h0, ctrl});
    apb(1'b1, `RSP_OFF_IEN, {27'h0, ctrl[1], 4'h0});
    for (int i = 0; i < n; i++) begin
      b = 8'($random(seed));
      exq.push_back(b);
      wait_bit(`RSP_OFF_TXD, 31, 1'b0);
      apb(1'b1, `RSP_OFF_TXD, {23'h0, i == n - 1, b});
    end
    wait_bit(`RSP_OFF_STAT, 4, 1'b1);
    check("tx stat", rq, 32'h10);
    check("irq masked", irq, ctrl[1]);
    // Slow serial bytes reach the device up to ten segments later
    for (int k = 0; k < 1000 && txq.size() < n; k++) @(posedge clk_in);
    repeat (20) @(posedge clk_in);
    check("tx count", txq.size(), n);
    foreach (exq[i]) check("tx byte", txq[i], exq[i]);
    txq.delete();
    exq.delete();
    apb(1'b1, `RSP_OFF_ICLR, 32'h1f);
    apb(1'b0, `RSP_OFF_STAT, 32'h0);
    check("stat cleared", rq, 32'h0);
    check("irq cleared", irq, 1'b0);
  endtask
  task automatic rx_frame(input logic [5:0] ctrl, input int n, input logic err);
    logic [7:0] b;
    speed <= ctrl[1];
    apb(1'b1, `RSP_OFF_CTRL, {26'h0, ctrl});
    for (int i = 0; i < n; i++) begin
      b = 8'($random(seed));
      // MAC aligns on the first non-zero di-bit, so lead with one
      if (i == 0) b[0] = 1'b1;
      rxq.push_back(b);
    end
    exq = rxq;
    rx_err <= err;
    rx_byte <= rxq.pop_front();
    carrier <= 1'b1;
    foreach (exq[i]) begin
      wait_bit(`RSP_OFF_STAT, 0, 1'b1);
      apb(1'b0, `RSP_OFF_RXD, 32'h0);
      check("rx byte", rq[7:0], exq[i]);
      apb(1'b1, `RSP_OFF_ICLR, 32'h1);
    end
    wait_bit(`RSP_OFF_STAT, 1, 1'b1);
    rx_err <= 1'b0;
    repeat (200) @(posedge clk_in);
    apb(1'b0, `RSP_OFF_STAT, 32'h0);
    check("rx error flag", rq[2], err);
    if (ctrl[0]) begin
      apb(1'b0, `RSP_OFF_LSTAT, 32'h0);
      check("rx status", rq[7:0], {1'b1, false_carrier, 1'b1, jabber,
        link_up, duplex, speed, err});
    end
    apb(1'b1, `RSP_OFF_ICLR, 32'h1f);
    exq.delete();
  endtask
  always @(posedge clk_in) begin
    if (tx_valid === 1'b1) txq.push_back(tx_byte);
  end
  always @(posedge clk_in) begin
    if (rx_take === 1'b1) begin
      if (rxq.size() > 0) rx_byte <= rxq.pop_front();
      else carrier <= 1'b0;
    end
  end
  // Limit sized well above the longest run, the slow serial frames
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 60000) begin
      n_mismatch++;
      close_out();
    end
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata, straps} = '0;
    {speed, duplex, link_up, jabber, carrier, rx_err} = '0;
    {false_carrier, rx_byte} = '0;
    rst_in = 1'b1;
    seed = 37693;
    do_reset(3'h0);
    check("mode off", mode, 2'h0);
    do_reset(`RSP_STRAP_REDUCED);
    check("mode reduced", mode, 2'h1);
    apb(1'b0, `RSP_OFF_CTRL, 32'h0);
    check("ctrl reset", rq, 32'h0);
    apb(1'b0, 8'hfc, 32'h0);
    check("unmapped err", re, 1'b1);
    check("unmapped data", rq, 32'h0);
    for (int s = 1; s >= 0; s--) begin
      tx_frame(6'h0c | 6'(s << 1), 5);
      rx_frame(6'h0c | 6'(s << 1), 4, s == 0);
    end
    do_reset(`RSP_STRAP_SERIAL);
    check("mode serial", mode, 2'h2);
    {duplex, link_up, jabber, false_carrier} <= 4'($random(seed));
    b4 = 4'($random(seed));
    speed <= b4[0];
    apb(1'b1, `RSP_OFF_CTRL, {27'h0, b4, 1'b1});
    repeat (1000) @(posedge clk_in);
    check("mac status", mac_stat, b4);
    for (int s = 1; s >= 0; s--) begin
      tx_frame(6'h01 | 6'(s << 1), 3);
      rx_frame(6'h01 | 6'(s << 1), 3, s == 1);
    end
    close_out();
  end
endmodule
